// ===== hdl/rics_phase_timer.sv
// Down-counter that times each phase of an external cycle.
`timescale 1ns/1ns
module rics_phase_timer
  import rics_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic [7:0] length,
  // Status
  output logic expired
);

  typedef struct packed {
    logic [7:0] cnt;
  } rics_timer_t;

  rics_timer_t st_r;
  rics_timer_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (start)
    begin
      st_nxt.cnt = length;
    end
    else if (st_r.cnt != 8'h00)
    begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // The phase ends in its last counted cycle.
  assign expired = (st_r.cnt == 8'h01);

endmodule : rics_phase_timer

// ===== hdl/rics_pkg.sv
// Package with the shared constants, states and carriers of the ROM and I/O cycle sequencer.
package rics_pkg;

  // Clock and timing, each time in ns as printed and its derived cycle count.
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_SETUP_NS = 20;
  localparam int ROM_ACCESS_NS = 150;
  localparam int IO_STROBE_NS = 250;
  localparam int ADDR_HOLD_NS = 20;
  localparam logic [7:0] ADDR_SETUP_CYC = 8'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ROM_ACCESS_CYC = 8'((ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] IO_STROBE_CYC = 8'((IO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ADDR_HOLD_CYC = 8'((ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Address map fields.
  localparam int QUAD_HI = 31;
  localparam int QUAD_LO = 30;
  localparam logic [1:0] QUAD_ROM = 2'h2;
  localparam logic [1:0] QUAD_BOOT = 2'h0;
  localparam logic [1:0] QUAD_IO = 2'h3;
  localparam int ROM_HALF_BIT = 29;
  localparam int BYTE_SEL_HI = 23;
  localparam int BYTE_SEL_LO = 22;
  localparam int ROM_WORD_HI = 19;
  localparam int ROM_WORD_LO = 2;
  localparam int IO_SPACE_BIT = 25;
  localparam int BUF_ADDR_W = 26;
  localparam int IO_DATA_W = 16;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    RICS_IDLE = 5'b00001,
    RICS_SETUP = 5'b00010,
    RICS_STROBE = 5'b00100,
    RICS_HOLD = 5'b01000,
    RICS_DONE = 5'b10000
  } rics_state_t;

  // Processor request and answer.
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rics_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } rics_rsp_t;

endpackage : rics_pkg

// ===== hdl/rics_sequencer.sv
// ROM and I/O cycle sequencer between the processor bus and the byte-wide ROMs and peripherals.
//
// Operation
// - I/O data bus carries the low 16 bits of the processor data.
// - Both ROMs always decode in the quadrant where address bits 31:30 are 10.
// - After reset ROMs also decode in quadrant 00 for boot fetches.
// - Jumper input picks which ROM sits in the lower half of the quadrant.
// - Jumper absent puts the Flash in the lower half so booting uses Flash.
// - ROM reads drive the two lowest ROM address lines from the byte counter.
// - Each ROM read fetches four bytes and returns one packed 32-bit word.
// - Flash write loads the byte counter from address bits 23:22.
// - Upper Flash address lines come from buffered address bits 19:2.
// - Peripheral accesses produce ISA-style I/O read and write strobes.
// - Address bit 25 drives the peripheral enable line; high means external space.
// - Peripheral reads take only the low byte lane of the I/O bus; writes drive all 16 bits.
`timescale 1ns/1ns
module rics_sequencer
  import rics_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Processor side
  input rics_req_t cpu_req,
  output rics_rsp_t cpu_rsp,
  output logic cpu_busy,
  // Board straps and control
  input wire logic eprom_boot_n,
  input wire logic boot_alias_clear,
  output logic boot_alias_on,
  // Buffered address and ROM controls
  output logic [BUF_ADDR_W-1:0] buf_addr,
  output logic [ROM_WORD_HI-ROM_WORD_LO:0] rom_word_addr,
  output logic [1:0] rom_byte_addr,
  output logic flash_cs_n,
  output logic eprom_cs_n,
  output logic rom_oe_n,
  output logic rom_we_n,
  // I/O bus and strobes
  input wire logic [IO_DATA_W-1:0] io_data_in,
  output logic [IO_DATA_W-1:0] io_data_out,
  output logic io_data_oe,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic io_space_select_line
);

  typedef struct packed {
    rics_state_t state;
    logic alias_on;
    logic we;
    logic is_rom;
    logic is_io;
    logic is_flash;
    logic [1:0] cnt;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rom_sel;
    logic flash_sel;
    logic eprom_sel;
    logic oe;
    logic wr;
    logic ior;
    logic iow;
    logic drive;
  } rics_seq_t;

  localparam rics_seq_t SEQ_RESET = '{
    state: RICS_IDLE,
    alias_on: 1'b1,
    we: 1'b0,
    is_rom: 1'b0,
    is_io: 1'b0,
    is_flash: 1'b0,
    cnt: 2'h0,
    addr: DATA_RESET,
    wdata: DATA_RESET,
    rdata: DATA_RESET,
    rom_sel: 1'b0,
    flash_sel: 1'b0,
    eprom_sel: 1'b0,
    oe: 1'b0,
    wr: 1'b0,
    ior: 1'b0,
    iow: 1'b0,
    drive: 1'b0
  };

  rics_seq_t st_r;
  rics_seq_t st_nxt;
  logic tmr_start;
  logic [7:0] tmr_len;
  logic tmr_done;

  // Decides whether an address reaches the ROMs, given the boot alias state.
  function automatic logic rom_hit(input logic [31:0] a, input logic alias_on);
    rom_hit = (a[QUAD_HI:QUAD_LO] == QUAD_ROM) ||
              (alias_on && (a[QUAD_HI:QUAD_LO] == QUAD_BOOT));
  endfunction : rom_hit

  // Selects the Flash for the lower half when the boot jumper is absent.
  function automatic logic flash_hit(input logic [31:0] a, input logic boot_eprom_n);
    flash_hit = a[ROM_HALF_BIT] ? !boot_eprom_n : boot_eprom_n;
  endfunction : flash_hit

  rics_phase_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .length(tmr_len),
    .expired(tmr_done)
  );

  always_comb
  begin
    st_nxt = st_r;
    tmr_start = 1'b0;
    tmr_len = ADDR_SETUP_CYC;
    if (boot_alias_clear)
    begin
      st_nxt.alias_on = 1'b0;
    end
    unique case (st_r.state)
      RICS_IDLE:
      begin
        if (cpu_req.valid)
        begin
          st_nxt.addr = cpu_req.addr;
          st_nxt.wdata = cpu_req.wdata;
          st_nxt.we = cpu_req.we;
          st_nxt.rdata = DATA_RESET;
          st_nxt.is_rom = rom_hit(cpu_req.addr, st_r.alias_on);
          st_nxt.is_io = (cpu_req.addr[QUAD_HI:QUAD_LO] == QUAD_IO);
          st_nxt.is_flash = flash_hit(cpu_req.addr, eprom_boot_n);
          if (cpu_req.we)
          begin
            st_nxt.cnt = cpu_req.addr[BYTE_SEL_HI:BYTE_SEL_LO];
          end
          else
          begin
            st_nxt.cnt = 2'h0;
          end
          if (st_nxt.is_rom || st_nxt.is_io)
          begin
            st_nxt.state = RICS_SETUP;
            st_nxt.rom_sel = st_nxt.is_rom;
            st_nxt.flash_sel = st_nxt.is_rom && st_nxt.is_flash;
            st_nxt.eprom_sel = st_nxt.is_rom && !st_nxt.is_flash;
            st_nxt.drive = cpu_req.we;
            tmr_start = 1'b1;
            tmr_len = ADDR_SETUP_CYC;
          end
          else
          begin
            st_nxt.state = RICS_DONE;
          end
        end
      end
      RICS_SETUP:
      begin
        if (tmr_done)
        begin
          st_nxt.state = RICS_STROBE;
          tmr_start = 1'b1;
          if (st_r.is_rom)
          begin
            tmr_len = ROM_ACCESS_CYC;
            st_nxt.oe = !st_r.we;
            st_nxt.wr = st_r.we && st_r.is_flash;
          end
          else
          begin
            tmr_len = IO_STROBE_CYC;
            st_nxt.ior = !st_r.we;
            st_nxt.iow = st_r.we;
          end
        end
      end
      RICS_STROBE:
      begin
        if (tmr_done)
        begin
          st_nxt.oe = 1'b0;
          st_nxt.wr = 1'b0;
          st_nxt.ior = 1'b0;
          st_nxt.iow = 1'b0;
          if (!st_r.we && st_r.is_rom)
          begin
            st_nxt.rdata[8*st_r.cnt +: 8] = io_data_in[7:0];
          end
          else if (!st_r.we)
          begin
            st_nxt.rdata = {24'h00_0000, io_data_in[7:0]};
          end
          tmr_start = 1'b1;
          if (!st_r.we && st_r.is_rom && (st_r.cnt != LAST_BYTE))
          begin
            st_nxt.cnt = st_r.cnt + 2'h1;
            st_nxt.state = RICS_SETUP;
            tmr_len = ADDR_SETUP_CYC;
          end
          else
          begin
            st_nxt.state = RICS_HOLD;
            tmr_len = ADDR_HOLD_CYC;
          end
        end
      end
      RICS_HOLD:
      begin
        if (tmr_done)
        begin
          st_nxt.state = RICS_DONE;
          st_nxt.rom_sel = 1'b0;
          st_nxt.flash_sel = 1'b0;
          st_nxt.eprom_sel = 1'b0;
          st_nxt.drive = 1'b0;
        end
      end
      RICS_DONE:
      begin
        st_nxt.state = RICS_IDLE;
      end
      default:
      begin
        st_nxt = SEQ_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_r <= SEQ_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Processor answer.
  assign cpu_rsp.ack = (st_r.state == RICS_DONE);
  assign cpu_rsp.rdata = st_r.rdata;
  assign cpu_busy = (st_r.state != RICS_IDLE);
  assign boot_alias_on = st_r.alias_on;

  // Buffered, word and space address outputs held for the whole cycle; the byte address follows the counter.
  assign buf_addr = st_r.addr[BUF_ADDR_W-1:0];
  assign rom_word_addr = st_r.addr[ROM_WORD_HI:ROM_WORD_LO];
  assign rom_byte_addr = st_r.cnt;
  assign io_space_select_line = st_r.addr[IO_SPACE_BIT];

  // ROM strobes.
  assign flash_cs_n = !st_r.flash_sel;
  assign eprom_cs_n = !st_r.eprom_sel;
  assign rom_oe_n = !st_r.oe;
  assign rom_we_n = !st_r.wr;

  // I/O bus; the byte-wide parts listen on the low lane only.
  assign io_data_out = st_r.wdata[IO_DATA_W-1:0];
  assign io_data_oe = st_r.drive;
  assign io_rd_n = !st_r.ior;
  assign io_wr_n = !st_r.iow;

endmodule : rics_sequencer

// ===== tb/rics_checker.sv
// Assertion checker for the ports of the ROM and I/O cycle sequencer.
`timescale 1ns/1ns
module rics_checker
  import rics_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Processor side
  input rics_req_t cpu_req,
  input rics_rsp_t cpu_rsp,
  input wire logic boot_alias_clear,
  input wire logic boot_alias_on,
  // ROM and I/O side
  input wire logic [BUF_ADDR_W-1:0] buf_addr,
  input wire logic [ROM_WORD_HI-ROM_WORD_LO:0] rom_word_addr,
  input wire logic [1:0] rom_byte_addr,
  input wire logic flash_cs_n,
  input wire logic eprom_cs_n,
  input wire logic rom_oe_n,
  input wire logic rom_we_n,
  input wire logic [IO_DATA_W-1:0] io_data_out,
  input wire logic io_data_oe,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic io_space_select_line
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  io_lane_low_a: assert property ($rose(io_data_oe) |-> io_data_out == $past(cpu_req.wdata[15:0]))
    else $error("I/O bus does not carry the low data half");
  rom_one_chip_a: assert property (!(!flash_cs_n && !eprom_cs_n))
    else $error("both ROM selects active");
  rom_strobe_hold_a: assert property ($fell(rom_oe_n) |-> (!rom_oe_n && $stable(rom_byte_addr))[*8])
    else $error("byte counter moved during a ROM strobe");
  flash_counter_a: assert property ($fell(rom_we_n) |-> rom_byte_addr == buf_addr[BYTE_SEL_HI:BYTE_SEL_LO])
    else $error("Flash byte counter not loaded from the address");
  word_addr_a: assert property (rom_word_addr == buf_addr[ROM_WORD_HI:ROM_WORD_LO])
    else $error("ROM word address differs from buffered address");
  io_write_strobe_a: assert property ($fell(io_wr_n) |-> (!io_wr_n && io_data_oe && io_rd_n)[*8])
    else $error("I/O write strobe malformed");
  space_line_a: assert property (io_space_select_line == buf_addr[IO_SPACE_BIT])
    else $error("space select line differs from address bit");
  alias_clear_a: assert property (boot_alias_clear || !boot_alias_on |=> !boot_alias_on)
    else $error("boot alias not removed or came back");
  ack_pulse_a: assert property (cpu_rsp.ack |=> !cpu_rsp.ack)
    else $error("ack longer than one cycle");
  cover property ($fell(rom_oe_n));
  cover property ($fell(rom_we_n));
  cover property ($fell(io_rd_n));
endmodule : rics_checker
bind rics_sequencer rics_checker chk (.sys_clk, .reset_n, .cpu_req, .cpu_rsp, .boot_alias_clear, .boot_alias_on,
  .buf_addr, .rom_word_addr, .rom_byte_addr, .flash_cs_n, .eprom_cs_n, .rom_oe_n, .rom_we_n, .io_data_out,
  .io_data_oe, .io_rd_n, .io_wr_n, .io_space_select_line);

// ===== tb/rics_rom_io_model.sv
// Behavioural model of the byte-wide ROMs and the self-decoding peripheral.
`timescale 1ns/1ns
module rics_rom_io_model
  import rics_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // ROM side
  input wire logic flash_cs_n,
  input wire logic eprom_cs_n,
  input wire logic rom_oe_n,
  input wire logic [ROM_WORD_HI-ROM_WORD_LO:0] rom_word_addr,
  input wire logic [1:0] rom_byte_addr,
  // Peripheral side
  input wire logic [BUF_ADDR_W-1:0] buf_addr,
  input wire logic io_rd_n,
  input wire logic io_space_select_line,
  output logic [IO_DATA_W-1:0] io_data_in
);
  logic [IO_DATA_W-1:0] last_r = 16'h0000;
  logic rom_on;
  logic io_on;
  assign rom_on = !rom_oe_n && !(flash_cs_n && eprom_cs_n);
  assign io_on = !io_rd_n && !io_space_select_line;
  // Each ROM byte names its chip, word and byte; a released bus shows the inverse of its last value.
  assign io_data_in = rom_on ? {8'hFF, !flash_cs_n, rom_word_addr[2:0], 2'h0, rom_byte_addr}
    : io_on ? {8'hFF, 8'h5A ^ buf_addr[7:0]} : ~last_r;
  always @(posedge sys_clk) last_r <= io_data_in;
endmodule : rics_rom_io_model

// ===== tb/rom_io_cycle_sequencer_test.sv
// Self-checking testbench of the ROM and I/O cycle sequencer.
`timescale 1ns/1ns
module rom_io_cycle_sequencer_test
  import rics_pkg::*;
;
  logic sys_clk, reset_n, cpu_busy, eprom_boot_n, boot_alias_clear, boot_alias_on;
  rics_req_t cpu_req;
  rics_rsp_t cpu_rsp;
  logic [BUF_ADDR_W-1:0] buf_addr;
  logic [ROM_WORD_HI-ROM_WORD_LO:0] rom_word_addr;
  logic [1:0] rom_byte_addr, wr_ctr;
  logic flash_cs_n, eprom_cs_n, rom_oe_n, rom_we_n, io_data_oe, io_rd_n, io_wr_n, io_space_select_line;
  logic [IO_DATA_W-1:0] io_data_in, io_data_out;
  logic [7:0] wr_lane;
  logic [31:0] d;
  int errors = 0;
  int compares = 0;
  rics_sequencer dut (.*);
  rics_rom_io_model far_end (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Records what a Flash write strobe carried.
  always @(negedge sys_clk)
    if (!rom_we_n)
    begin
      wr_ctr <= rom_byte_addr;
      wr_lane <= io_data_out[7:0];
    end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic access(input logic we, input logic [31:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge sys_clk);
    cpu_req <= '{valid: 1'b1, we: we, addr: addr, wdata: wdata};
    @(posedge sys_clk);
    cpu_req.valid <= 1'b0;
    @(negedge sys_clk);
    check("busy", 1, cpu_busy);
    while (cpu_rsp.ack !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("ack", 1, cpu_rsp.ack);
    d = cpu_rsp.rdata;
  endtask : access
  task automatic rom_reads;
    access(0, 32'h0000_0010, 0);
    check("boot flash word", 32'hC3C2_C1C0, d);
    access(0, 32'hA000_0008, 0);
    check("upper eprom word", 32'h2322_2120, d);
    access(0, 32'h4000_0010, 0);
    check("quadrant 01 read", 0, d);
    @(posedge sys_clk);
    eprom_boot_n <= 1'b0;
    access(0, 32'h8000_000C, 0);
    check("lower eprom word", 32'h3332_3130, d);
    access(0, 32'hA000_0004, 0);
    check("upper flash word", 32'h9392_9190, d);
    @(posedge sys_clk);
    eprom_boot_n <= 1'b1;
  endtask : rom_reads
  task automatic flash_write;
    access(1, 32'h80C0_0004, 32'h1234_5678);
    check("flash counter", 3, wr_ctr);
    check("flash lane", 8'h78, wr_lane);
    check("flash word addr", 1, rom_word_addr);
    access(1, 32'hA000_0000, 32'h0000_00EE);
    check("eprom not written", 8'h78, wr_lane);
  endtask : flash_write
  task automatic io_cycles;
    access(1, 32'hC200_0010, 32'h0000_ABCD);
    check("space line", 1, io_space_select_line);
    check("io out", 16'hABCD, io_data_out);
    access(0, 32'hC000_0021, 0);
    check("space line", 0, io_space_select_line);
    check("io read", 32'h0000_007B, d);
  endtask : io_cycles
  task automatic alias_cycle;
    @(posedge sys_clk);
    boot_alias_clear <= 1'b1;
    @(posedge sys_clk);
    boot_alias_clear <= 1'b0;
    @(negedge sys_clk);
    check("alias off", 0, boot_alias_on);
    access(0, 32'h0000_0010, 0);
    check("unmapped read", 0, d);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check("alias on", 1, boot_alias_on);
    access(0, 32'h0000_0010, 0);
    check("boot again", 32'hC3C2_C1C0, d);
  endtask : alias_cycle
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    cpu_req = '0;
    reset_n = 1'b0;
    eprom_boot_n = 1'b1;
    boot_alias_clear = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    rom_reads();
    flash_write();
    io_cycles();
    alias_cycle();
    complete_run();
  end
  initial
  begin
    #30000;
    errors++;
    complete_run();
  end
endmodule : rom_io_cycle_sequencer_test
